/* File: monitor_config_fan_control_regs.sv */
// Configuration and fan-control register bank of the hardware monitor.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - With the monitor bit set, the pointer steps round all channels.
// - The interrupt pin goes active only while interrupts are enabled.
// - Writing 1 to the clear bit drops the limit latch; the bit clears.
// - General I/O interrupts are levels that the clear bit leaves alone.
// - After a clear, monitoring goes on and a new violation sets it again.
// - The pair bit picks inputs nine and ten when 1, the second diode at 0.
// - With overtemp enabled, the overtemp output is low while exceeded.
// - With analog auto off the DAC drives the analog level register.
// - With pulse auto off the PWM duty is the pulse level field.
// - Writing 1 to the init bit restores every reset value, then clears.
// - Each pin-function bit picks general I/O at 1 and a tach input at 0.
// - Each two-bit prescaler code divides the reference by 1, 2, 4 or 8.
// - Codes pack four a byte; the high register for fans 4-7 resets 55h.
// - The analog level is the manual DAC value; top nibble is auto floor.
// - The pulse duty sits in bits 7-2, auto floor in the top nibble.
module monitor_config_fan_control_regs
    import monitor_config_pkg::*;
#(
    parameter int NUM_CHANNELS = 16,
    parameter int NUM_FANS     = 8
)(
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Register port from the management bus engine
    input  wire logic [7:0]              reg_addr,
    input  wire logic                    reg_wr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_rd,
    output logic [7:0]                   reg_rdata,
    // Measurement sequencing
    input  wire logic                    conv_done,
    output logic                         monitor_active,
    output logic [7:0]                   meas_channel,
    output logic                         pass_done,
    output logic                         sel_voltage_pair,
    // Interrupt sources and pin (active low)
    input  wire logic                    limit_violation,
    input  wire logic                    gpio_irq_level,
    output logic                         irq_n,
    // Overtemperature (active low)
    input  wire logic                    overtemp_exceeded,
    output logic                         overtemp_output_n,
    // Fan speed control
    input  wire logic [7:0]              auto_dac_level,
    input  wire logic [PWM_W-1:0]        auto_pwm_duty,
    output logic [7:0]                   dac_level,
    output logic [PWM_W-1:0]             pwm_duty,
    // Pin functions and tach prescalers
    output logic [7:0]                   pin_function,
    input  wire logic                    ref_tick,
    output logic [NUM_FANS-1:0]          tach_tick
);

    typedef struct packed {
        logic [7:0]       ctl;
        logic [7:0]       pinf;
        logic [7:0]       div_lo;
        logic [7:0]       div_hi;
        logic [7:0]       lvl_a;
        logic [7:0]       lvl_p;
        logic [7:0]       rdata;
        logic [7:0]       chan;
        logic             pass_done;
        logic             irq_latch;
        logic             irq_n;
        logic             ot_n;
        logic [7:0]       dac;
        logic [PWM_W-1:0] pwm;
    } bank_state_t;

    localparam logic [7:0] CHAN_LAST = 8'(NUM_CHANNELS - 1);

    bank_state_t st_ff;
    bank_state_t nxt_st;
    logic [15:0] div_codes;
    logic [7:0]  dac_floor;
    logic [PWM_W-1:0] pwm_floor;

    assign div_codes = {st_ff.div_hi, st_ff.div_lo};
    assign dac_floor = {st_ff.lvl_a[7:MIN_NIBBLE_LSB], 4'h0};
    assign pwm_floor = {st_ff.lvl_p[7:MIN_NIBBLE_LSB], 2'h0};

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb begin
        nxt_st           = st_ff;
        nxt_st.pass_done = 1'b0;

        // Command bits live for one cycle so software sees them drop at once.
        nxt_st.ctl[BIT_IRQ_CLEAR] = 1'b0;
        nxt_st.ctl[BIT_INIT]      = 1'b0;

        if (st_ff.ctl[BIT_INIT]) begin
            // Init beats a write arriving in the same cycle.
            nxt_st.ctl    = RST_CONTROL_ONE;
            nxt_st.pinf   = RST_PIN_FUNCTION;
            nxt_st.div_lo = RST_PRESCALE_LOW;
            nxt_st.div_hi = RST_PRESCALE_HIGH;
            nxt_st.lvl_a  = RST_LEVEL_ANALOG;
            nxt_st.lvl_p  = RST_LEVEL_PULSE;
        end else if (reg_wr) begin
            case (reg_addr)
                OFS_CONTROL_ONE:   nxt_st.ctl    = reg_wdata;
                OFS_PIN_FUNCTION:  nxt_st.pinf   = reg_wdata;
                OFS_PRESCALE_LOW:  nxt_st.div_lo = reg_wdata;
                OFS_PRESCALE_HIGH: nxt_st.div_hi = reg_wdata;
                OFS_LEVEL_ANALOG:  nxt_st.lvl_a  = reg_wdata;
                OFS_LEVEL_PULSE:   nxt_st.lvl_p  = reg_wdata;
                default: ;
            endcase
        end

        if (reg_rd) begin
            case (reg_addr)
                OFS_CONTROL_ONE:   nxt_st.rdata = st_ff.ctl;
                OFS_PIN_FUNCTION:  nxt_st.rdata = st_ff.pinf;
                OFS_PRESCALE_LOW:  nxt_st.rdata = st_ff.div_lo;
                OFS_PRESCALE_HIGH: nxt_st.rdata = st_ff.div_hi;
                OFS_LEVEL_ANALOG:  nxt_st.rdata = st_ff.lvl_a;
                OFS_LEVEL_PULSE:   nxt_st.rdata = st_ff.lvl_p & PULSE_RO_MASK;
                default:           nxt_st.rdata = 8'h00;
            endcase
        end

        // Round-robin pointer; parked at zero while monitoring is off.
        if (!st_ff.ctl[BIT_MONITOR]) begin
            nxt_st.chan = 8'h00;
        end else if (conv_done) begin
            if (st_ff.chan >= CHAN_LAST) begin
                nxt_st.chan      = 8'h00;
                nxt_st.pass_done = 1'b1;
            end else begin
                nxt_st.chan = st_ff.chan + 8'h01;
            end
        end

        // A violation in the clear cycle is kept: set wins over clear.
        if (st_ff.ctl[BIT_IRQ_CLEAR] || st_ff.ctl[BIT_INIT]) begin
            nxt_st.irq_latch = 1'b0;
        end
        if (limit_violation) begin
            nxt_st.irq_latch = 1'b1;
        end

        // GPIO level bypasses the latch, so a clear cannot hide it.
        nxt_st.irq_n = ~(st_ff.ctl[BIT_IRQ_ENABLE] &
                         (st_ff.irq_latch | gpio_irq_level));

        nxt_st.ot_n = ~(st_ff.ctl[BIT_OT_ENABLE] & overtemp_exceeded);

        if (st_ff.ctl[BIT_DAC_AUTO]) begin
            nxt_st.dac = (auto_dac_level > dac_floor) ?
                         auto_dac_level : dac_floor;
        end else begin
            nxt_st.dac = st_ff.lvl_a;
        end

        if (st_ff.ctl[BIT_PWM_AUTO]) begin
            nxt_st.pwm = (auto_pwm_duty > pwm_floor) ?
                         auto_pwm_duty : pwm_floor;
        end else begin
            nxt_st.pwm = st_ff.lvl_p[7:PWM_FIELD_LSB];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff        <= '0;
            st_ff.div_hi <= RST_PRESCALE_HIGH;
            st_ff.lvl_a  <= RST_LEVEL_ANALOG;
            st_ff.lvl_p  <= RST_LEVEL_PULSE;
            st_ff.irq_n  <= 1'b1;
            st_ff.ot_n   <= 1'b1;
            st_ff.dac    <= RST_LEVEL_ANALOG;
            st_ff.pwm    <= '1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tach prescalers, one per fan.

    genvar fan;
    generate
        for (fan = 0; fan < NUM_FANS; fan++) begin : g_fan
            fan_prescaler u_pre (
                .clk      (clk),
                .rst      (rst),
                .ref_tick (ref_tick),
                .div_code (div_codes[fan*DIV_CODE_W +: DIV_CODE_W]),
                .tick     (tach_tick[fan])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign reg_rdata         = st_ff.rdata;
    assign monitor_active    = st_ff.ctl[BIT_MONITOR];
    assign meas_channel      = st_ff.chan;
    assign pass_done         = st_ff.pass_done;
    assign sel_voltage_pair  = st_ff.ctl[BIT_VOLT_PAIR];
    assign irq_n             = st_ff.irq_n;
    assign overtemp_output_n = st_ff.ot_n;
    assign dac_level         = st_ff.dac;
    assign pwm_duty          = st_ff.pwm;
    assign pin_function      = st_ff.pinf;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence wr_ctl_bit(int b);
        reg_wr && !st_ff.ctl[BIT_INIT] && reg_addr == OFS_CONTROL_ONE &&
            reg_wdata[b];
    endsequence

    sequence pulse_then_drop(int b);
        st_ff.ctl[b] ##1 !st_ff.ctl[b];
    endsequence

    round_robin_a: assert property (st_ff.ctl[BIT_MONITOR] && conv_done &&
        st_ff.chan == CHAN_LAST |=> st_ff.chan == 8'h00 && pass_done)
        else $error("channel pointer did not wrap at end of pass");

    irq_gate_a: assert property (!st_ff.ctl[BIT_IRQ_ENABLE] |=> irq_n)
        else $error("interrupt pin active while disabled");

    irq_clear_a: assert property (wr_ctl_bit(BIT_IRQ_CLEAR) |=>
        pulse_then_drop(BIT_IRQ_CLEAR))
        else $error("interrupt clear bit did not pulse and self-clear");

    latch_drop_a: assert property (st_ff.ctl[BIT_IRQ_CLEAR] && !limit_violation
        |=> !st_ff.irq_latch)
        else $error("interrupt latch survived clear");

    gpio_level_a: assert property (st_ff.ctl[BIT_IRQ_ENABLE] && gpio_irq_level
        && $stable(st_ff.ctl[BIT_IRQ_ENABLE]) |=> !irq_n)
        else $error("general io level interrupt lost");

    rearm_a: assert property (limit_violation ##1 st_ff.ctl[BIT_IRQ_ENABLE]
        |=> !irq_n)
        else $error("violation did not raise interrupt");

    overtemp_a: assert property (st_ff.ctl[BIT_OT_ENABLE] && overtemp_exceeded
        |=> !overtemp_output_n)
        else $error("overtemp output not driven low");

    dac_manual_a: assert property (!st_ff.ctl[BIT_DAC_AUTO]
        |=> dac_level == $past(st_ff.lvl_a))
        else $error("dac does not follow analog level register");

    pwm_manual_a: assert property (!st_ff.ctl[BIT_PWM_AUTO]
        |=> pwm_duty == $past(st_ff.lvl_p[7:2]))
        else $error("pwm duty does not follow pulse level field");

    init_restore_a: assert property (wr_ctl_bit(BIT_INIT) |=> ##1
        st_ff.ctl == RST_CONTROL_ONE && st_ff.div_hi == RST_PRESCALE_HIGH &&
        st_ff.lvl_a == RST_LEVEL_ANALOG)
        else $error("init did not restore defaults");

    monitor_off_a: assert property (!st_ff.ctl[BIT_MONITOR]
        |=> meas_channel == 8'h00)
        else $error("channel pointer moved while monitoring off");

    pass_pulse_a: assert property (pass_done |=> !pass_done)
        else $error("pass done pulse lasted more than one cycle");

    ot_gate_a: assert property (!st_ff.ctl[BIT_OT_ENABLE]
        |=> overtemp_output_n)
        else $error("overtemp output low while disabled");

    init_drop_a: assert property (st_ff.ctl[BIT_INIT]
        |=> !st_ff.ctl[BIT_INIT] && st_ff.pinf == RST_PIN_FUNCTION)
        else $error("init bit did not clear or restore pin functions");

    pulse_read_a: assert property (reg_rd && reg_addr == OFS_LEVEL_PULSE
        |=> reg_rdata[1:0] == 2'h0)
        else $error("unused pulse level bits read nonzero");

endmodule : monitor_config_fan_control_regs

`default_nettype wire

/* File: monitor_config_pkg.sv */
// Offsets, field positions and reset values of the monitor control registers.
package monitor_config_pkg;

    // Register offsets.
    localparam logic [7:0] OFS_CONTROL_ONE   = 8'h00;
    localparam logic [7:0] OFS_PIN_FUNCTION  = 8'h01;
    localparam logic [7:0] OFS_PRESCALE_LOW  = 8'h02;
    localparam logic [7:0] OFS_PRESCALE_HIGH = 8'h03;
    localparam logic [7:0] OFS_LEVEL_ANALOG  = 8'h04;
    localparam logic [7:0] OFS_LEVEL_PULSE   = 8'h05;

    // Reset values.
    localparam logic [7:0] RST_CONTROL_ONE   = 8'h00;
    localparam logic [7:0] RST_PIN_FUNCTION  = 8'h00;
    localparam logic [7:0] RST_PRESCALE_LOW  = 8'h00;
    localparam logic [7:0] RST_PRESCALE_HIGH = 8'h55;
    localparam logic [7:0] RST_LEVEL_ANALOG  = 8'hff;
    localparam logic [7:0] RST_LEVEL_PULSE   = 8'hff;

    // Bit positions in the first control register.
    localparam int BIT_MONITOR    = 0;
    localparam int BIT_IRQ_ENABLE = 1;
    localparam int BIT_IRQ_CLEAR  = 2;
    localparam int BIT_VOLT_PAIR  = 3;
    localparam int BIT_OT_ENABLE  = 4;
    localparam int BIT_DAC_AUTO   = 5;
    localparam int BIT_PWM_AUTO   = 6;
    localparam int BIT_INIT       = 7;

    // Prescaler code field and fan-level layout.
    localparam int DIV_CODE_W     = 2;
    localparam int FANS_PER_REG   = 4;
    localparam int PWM_FIELD_LSB  = 2;
    localparam int PWM_W          = 6;
    localparam int MIN_NIBBLE_LSB = 4;
    localparam logic [7:0] PULSE_RO_MASK = 8'hfc;

endpackage : monitor_config_pkg

/* File: fan_prescaler.sv */
// Per-fan tach reference prescaler: divides the reference tick by 1, 2, 4 or 8.
`timescale 1ns/10ps
`default_nettype none

module fan_prescaler
    import monitor_config_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Reference and setting
    input  wire logic                  ref_tick,
    input  wire logic [DIV_CODE_W-1:0] div_code,
    // Divided tick
    output logic                       tick
);

    typedef struct packed {
        logic [2:0] cnt;
        logic       tick;
    } pre_state_t;

    pre_state_t st_ff;
    pre_state_t nxt_st;
    logic [2:0] last_count;

    // Code 00/01/10/11 gives 1/2/4/8 reference ticks per output tick.
    assign last_count = (3'h1 << div_code) - 3'h1;

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.tick = 1'b0;
        if (ref_tick) begin
            if (st_ff.cnt >= last_count) begin
                nxt_st.cnt  = 3'h0;
                nxt_st.tick = 1'b1;
            end else begin
                nxt_st.cnt = st_ff.cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick = st_ff.tick;

endmodule : fan_prescaler

`default_nettype wire

/* File: monitor_config_fan_control_regs_tb.sv */
// Self-checking testbench for the monitor control register bank.
`timescale 1ns/10ps
`default_nettype none

module monitor_config_fan_control_regs_tb;
    import monitor_config_pkg::*;

    localparam int NCH = 12;

    logic             clk = 1'b0;
    logic             rst = 1'b1;
    logic [7:0]       reg_addr = 8'h00;
    logic             reg_wr = 1'b0;
    logic [7:0]       reg_wdata = 8'h00;
    logic             reg_rd = 1'b0;
    logic [7:0]       reg_rdata;
    logic             conv_done = 1'b0;
    logic             monitor_active;
    logic [7:0]       meas_channel;
    logic             pass_done;
    logic             sel_voltage_pair;
    logic             limit_violation = 1'b0;
    logic             gpio_irq_level = 1'b0;
    logic             irq_n;
    logic             overtemp_exceeded = 1'b0;
    logic             overtemp_output_n;
    logic [7:0]       auto_dac_level = 8'h00;
    logic [PWM_W-1:0] auto_pwm_duty = 6'h00;
    logic [7:0]       dac_level;
    logic [PWM_W-1:0] pwm_duty;
    logic [7:0]       pin_function;
    logic             ref_tick = 1'b0;
    logic [7:0]       tach_tick;
    logic [7:0]       mdl [0:5];
    logic [7:0]       v;
    int               fails = 0;
    int               cmp_count = 0;
    int               pd_cnt = 0;
    int               tcnt [0:7];
    logic             count_en = 1'b0;

    monitor_config_fan_control_regs #(
        .NUM_CHANNELS(NCH), .NUM_FANS(8)
    ) i_monitor_config_fan_control_regs (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .conv_done(conv_done), .monitor_active(monitor_active),
        .meas_channel(meas_channel), .pass_done(pass_done),
        .sel_voltage_pair(sel_voltage_pair),
        .limit_violation(limit_violation), .gpio_irq_level(gpio_irq_level),
        .irq_n(irq_n), .overtemp_exceeded(overtemp_exceeded),
        .overtemp_output_n(overtemp_output_n),
        .auto_dac_level(auto_dac_level), .auto_pwm_duty(auto_pwm_duty),
        .dac_level(dac_level), .pwm_duty(pwm_duty),
        .pin_function(pin_function), .ref_tick(ref_tick),
        .tach_tick(tach_tick));

    always #5 clk = ~clk;

    // Event counters run on the design's clock so no pulse slips between checks.
    always @(posedge clk) begin
        pd_cnt <= pd_cnt + int'(pass_done);
        for (int f = 0; f < 8; f++) begin
            if (count_en && tach_tick[f] === 1'b1) begin
                tcnt[f] <= tcnt[f] + 1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic reset_model();
        mdl = '{RST_CONTROL_ONE, RST_PIN_FUNCTION, RST_PRESCALE_LOW,
                RST_PRESCALE_HIGH, RST_LEVEL_ANALOG, RST_LEVEL_PULSE};
    endtask : reset_model

    // Called at a falling edge; the write lands on the rising edge between.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
        if (a == OFS_CONTROL_ONE && d[BIT_INIT]) begin
            reset_model();
            cyc(1);
        end else if (a <= OFS_LEVEL_PULSE) begin
            mdl[a] = (a == OFS_CONTROL_ONE) ? (d & 8'h7b) : d;
        end
    endtask : wr

    task automatic rd_check(input logic [7:0] a);
        logic [7:0] e;
        reg_addr = a;
        reg_rd   = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
        e = (a > OFS_LEVEL_PULSE) ? 8'h00 : mdl[a];
        if (a == OFS_LEVEL_PULSE) e = e & PULSE_RO_MASK;
        check(reg_rdata, e);
    endtask : rd_check

    task automatic ref_pulses(input int n);
        repeat (n) begin
            ref_tick = 1'b1;
            cyc(1);
            ref_tick = 1'b0;
            cyc(3);
        end
    endtask : ref_pulses

    function automatic logic [7:0] mx(input logic [7:0] a, input logic [7:0] b);
        return (a > b) ? a : b;
    endfunction : mx

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #200us;
        fails++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'h4eb4));
        reset_model();
        cyc(3);
        rst = 1'b0;
        for (int a = 0; a < 7; a++) rd_check(8'(a));
        check(dac_level, RST_LEVEL_ANALOG);
        check({2'b00, pwm_duty}, 8'h3f);
        $display("test reset_values done");

        for (int k = 0; k < 4; k++) begin
            for (int a = 0; a < 7; a++) begin
                v = 8'($urandom);
                wr(8'(a), (a == 0) ? (v & 8'h1b) : v);
            end
            for (int a = 0; a < 7; a++) rd_check(8'(a));
            check(pin_function, mdl[1]);
            check({7'h0, sel_voltage_pair}, {7'h0, mdl[0][BIT_VOLT_PAIR]});
            check({7'h0, monitor_active}, {7'h0, mdl[0][BIT_MONITOR]});
            check(dac_level, mdl[4]);
            check({2'b00, pwm_duty}, {2'b00, mdl[5][7:2]});
        end
        $display("test register_access done");

        wr(OFS_CONTROL_ONE, 8'h60);
        for (int k = 0; k < 8; k++) begin
            auto_dac_level = 8'($urandom);
            auto_pwm_duty  = 6'($urandom);
            cyc(2);
            v = mx(auto_dac_level, {mdl[4][7:4], 4'h0});
            check(dac_level, v);
            v = mx({2'b00, auto_pwm_duty}, {2'b00, mdl[5][7:4], 2'b00});
            check({2'b00, pwm_duty}, v);
        end
        $display("test auto_fan done");

        wr(OFS_CONTROL_ONE, 8'h02);
        limit_violation = 1'b1;
        cyc(1);
        limit_violation = 1'b0;
        cyc(2);
        check({7'h0, irq_n}, 8'h00);
        gpio_irq_level = 1'b1;
        wr(OFS_CONTROL_ONE, 8'h06);
        cyc(2);
        check({7'h0, irq_n}, 8'h00);
        rd_check(OFS_CONTROL_ONE);
        gpio_irq_level = 1'b0;
        cyc(2);
        check({7'h0, irq_n}, 8'h01);
        wr(OFS_CONTROL_ONE, 8'h03);
        limit_violation = 1'b1;
        cyc(1);
        limit_violation = 1'b0;
        cyc(3);
        check({7'h0, irq_n}, 8'h00);
        wr(OFS_CONTROL_ONE, 8'h07);
        cyc(2);
        check({7'h0, irq_n}, 8'h01);
        wr(OFS_CONTROL_ONE, 8'h00);
        limit_violation = 1'b1;
        cyc(1);
        limit_violation = 1'b0;
        cyc(3);
        check({7'h0, irq_n}, 8'h01);
        wr(OFS_CONTROL_ONE, 8'h04);
        $display("test interrupt done");

        overtemp_exceeded = 1'b1;
        cyc(2);
        check({7'h0, overtemp_output_n}, 8'h01);
        wr(OFS_CONTROL_ONE, 8'h10);
        cyc(1);
        check({7'h0, overtemp_output_n}, 8'h00);
        overtemp_exceeded = 1'b0;
        cyc(2);
        check({7'h0, overtemp_output_n}, 8'h01);
        $display("test overtemp done");

        wr(OFS_CONTROL_ONE, 8'h01);
        for (int i = 0; i < 2 * NCH; i++) begin
            conv_done = 1'b1;
            cyc(1);
            conv_done = 1'b0;
            cyc(1);
            check(meas_channel, 8'((i + 1) % NCH));
        end
        check(8'(pd_cnt), 8'h02);
        wr(OFS_CONTROL_ONE, 8'h00);
        cyc(1);
        check(meas_channel, 8'h00);
        $display("test sequencer done");

        wr(OFS_PRESCALE_LOW, 8'he4);
        wr(OFS_PRESCALE_HIGH, 8'h1b);
        ref_pulses(8);
        count_en = 1'b1;
        ref_pulses(16);
        count_en = 1'b0;
        for (int f = 0; f < 8; f++) begin
            v = (f < 4) ? 8'(mdl[2] >> (2 * f)) : 8'(mdl[3] >> (2 * (f - 4)));
            check(8'(tcnt[f]), 8'(16 >> v[1:0]));
        end
        $display("test prescaler done");

        wr(OFS_PIN_FUNCTION, 8'h5a);
        wr(OFS_LEVEL_ANALOG, 8'h12);
        wr(OFS_CONTROL_ONE, 8'h80);
        cyc(1);
        for (int a = 0; a < 6; a++) rd_check(8'(a));
        check(dac_level, RST_LEVEL_ANALOG);
        $display("test init done");
        end_of_test();
    end

endmodule : monitor_config_fan_control_regs_tb

`default_nettype wire
